// file: pkg/prio_sel_pkg.sv
package prio_sel_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] PRIO_SEL_OFFSET      = 12'h000;
    localparam logic [11:0] PEND_STATUS_OFFSET   = 12'h004;
    localparam logic [11:0] ENABLE_OFFSET        = 12'h008;
    localparam logic [7:0]  PRIO_SEL_RESET       = 8'h00;
    localparam logic [7:0]  ENABLE_RESET         = 8'h00;
    localparam logic [7:0]  PRIO_SEL_IMPL_MASK   = 8'h7b;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CONV_IRQ_PRIO_BIT         = 6;
    localparam int SER_RX_IRQ_PRIO_BIT       = 5;
    localparam int SER_TX_IRQ_PRIO_BIT       = 4;
    localparam int SYNC_PORT_IRQ_PRIO_BIT    = 3;
    localparam int TIMER_B_MATCH_IRQ_PRIO_BIT = 1;
    localparam int TIMER_A_OVF_IRQ_PRIO_BIT  = 0;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

// file: core/prio_sel.sv
`timescale 1ns/1ps
// Functional notes
// - bits 7 and 2 always read zero
// - bit 6: converter interrupt high/low priority
// - bit 5: serial receive high/low priority
// - bit 4: serial transmit high/low priority
// - bit 3: sync port high/low priority
// - bit 1: timer b match high/low priority
// - bit 0: timer a overflow high/low priority
module prio_sel
    import prio_sel_pkg::*;
#(
    parameter int REG_W = 8                         // width of each register
)(
    input  wire logic             clk_i,            // core clock, 40 MHz
    input  wire logic             reset_i,          // synchronous, active high
    input  wire apb_req_t         apb_i,            // apb request
    output apb_rsp_t              apb_o,            // apb response, registered
    input  wire logic [REG_W-1:0] pend_i,           // source requests, priority bit layout
    output logic                  irq_hi_o,         // high priority interrupt
    output logic                  irq_lo_o          // low priority interrupt
);

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] IMPL_MASK = REG_W'(PRIO_SEL_IMPL_MASK);
    localparam logic [REG_W-1:0] PRIO_INIT = REG_W'(PRIO_SEL_RESET);
    localparam logic [REG_W-1:0] EN_INIT   = REG_W'(ENABLE_RESET);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ACCESS = 2'b01
    } bus_state_t;

    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    bus_state_t       state_r;
    bus_state_t       state_nxt;
    apb_rsp_t         rsp_r;
    apb_rsp_t         rsp_nxt;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [REG_W-1:0] prio_r;
    logic [REG_W-1:0] prio_nxt;
    logic [REG_W-1:0] en_r;
    logic [REG_W-1:0] en_nxt;

    // ------------------------------------------------------------
    // routing state
    // ------------------------------------------------------------
    logic             hi_r;
    logic             hi_nxt;
    logic             lo_r;
    logic             lo_nxt;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    logic             hit_prio;
    logic             hit_pend;
    logic             hit_en;
    logic             addr_hit;
    logic [REG_W-1:0] rd_byte;
    logic [31:0]      rd_word;
    logic [REG_W-1:0] wr_byte;
    logic             setup_phase;
    logic             access_write;

    // ------------------------------------------------------------
    // priority fields
    // ------------------------------------------------------------
    logic             conv_irq_prio;
    logic             ser_rx_irq_prio;
    logic             ser_tx_irq_prio;
    logic             sync_port_irq_prio;
    logic             timer_b_match_irq_prio;
    logic             timer_a_ovf_irq_prio;
    logic [REG_W-1:0] prio_map;

    // ------------------------------------------------------------
    // per-source routing
    // ------------------------------------------------------------
    logic [REG_W-1:0] src_act;
    logic [REG_W-1:0] src_hi;
    logic [REG_W-1:0] src_lo;

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        hit_prio = (apb_i.paddr == PRIO_SEL_OFFSET);
        hit_pend = (apb_i.paddr == PEND_STATUS_OFFSET);
        hit_en   = (apb_i.paddr == ENABLE_OFFSET);
        addr_hit = hit_prio | hit_pend | hit_en;
        rd_byte  = '0;
        if (hit_prio) begin
            rd_byte = prio_r & IMPL_MASK;
        end else if (hit_pend) begin
            rd_byte = pend_i & IMPL_MASK;
        end else if (hit_en) begin
            rd_byte = en_r & IMPL_MASK;
        end
        rd_word  = 32'(rd_byte);
        // unimplemented bits are dropped on write
        wr_byte  = apb_i.pwdata[REG_W-1:0] & IMPL_MASK;
    end

    assign setup_phase  = apb_i.psel && !apb_i.penable;
    assign access_write = apb_i.psel && apb_i.penable && apb_i.pwrite;

    // ------------------------------------------------------------
    // bus slave: answer in the cycle after setup
    // ------------------------------------------------------------
    // read data is latched at setup; no write lands in between, so prio and enable reads match the completion edge, pend_i may change
    always_comb begin
        state_nxt = state_r;
        rsp_nxt   = '0;
        unique case (state_r)
            BUS_IDLE: begin
                if (setup_phase) begin
                    state_nxt       = BUS_ACCESS;
                    rsp_nxt.pready  = 1'b1;
                    rsp_nxt.pslverr = !addr_hit;
                    if (!apb_i.pwrite) begin
                        rsp_nxt.prdata = rd_word;
                    end
                end
            end
            BUS_ACCESS: begin
                state_nxt = BUS_IDLE;
            end
            default: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= BUS_IDLE;
            rsp_r   <= '0;
        end else begin
            state_r <= state_nxt;
            rsp_r   <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // registers: a write lands only at the completion edge
    // ------------------------------------------------------------
    always_comb begin
        prio_nxt = prio_r;
        en_nxt   = en_r;
        if ((state_r == BUS_ACCESS) && access_write) begin
            if (hit_prio) begin
                prio_nxt = wr_byte;
            end
            if (hit_en) begin
                en_nxt = wr_byte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prio_r <= PRIO_INIT;
            en_r   <= EN_INIT;
        end else begin
            prio_r <= prio_nxt;
            en_r   <= en_nxt;
        end
    end

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    assign conv_irq_prio          = prio_r[CONV_IRQ_PRIO_BIT];
    assign ser_rx_irq_prio        = prio_r[SER_RX_IRQ_PRIO_BIT];
    assign ser_tx_irq_prio        = prio_r[SER_TX_IRQ_PRIO_BIT];
    assign sync_port_irq_prio     = prio_r[SYNC_PORT_IRQ_PRIO_BIT];
    assign timer_b_match_irq_prio = prio_r[TIMER_B_MATCH_IRQ_PRIO_BIT];
    assign timer_a_ovf_irq_prio   = prio_r[TIMER_A_OVF_IRQ_PRIO_BIT];

    // unimplemented positions stay zero so they never steer a request
    always_comb begin
        prio_map                             = '0;
        prio_map[CONV_IRQ_PRIO_BIT]          = conv_irq_prio;
        prio_map[SER_RX_IRQ_PRIO_BIT]        = ser_rx_irq_prio;
        prio_map[SER_TX_IRQ_PRIO_BIT]        = ser_tx_irq_prio;
        prio_map[SYNC_PORT_IRQ_PRIO_BIT]     = sync_port_irq_prio;
        prio_map[TIMER_B_MATCH_IRQ_PRIO_BIT] = timer_b_match_irq_prio;
        prio_map[TIMER_A_OVF_IRQ_PRIO_BIT]   = timer_a_ovf_irq_prio;
    end

    // ------------------------------------------------------------
    // routing
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < REG_W; g++) begin : g_src
            assign src_act[g] = pend_i[g] & en_r[g] & IMPL_MASK[g];
            assign src_hi[g]  = src_act[g] & prio_map[g];
            assign src_lo[g]  = src_act[g] & !prio_map[g];
        end
    endgenerate

    // outputs lag the inputs by one clock; kept registered for clean timing
    always_comb begin
        hi_nxt = |src_hi;
        lo_nxt = |src_lo;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign apb_o    = rsp_r;
    assign irq_hi_o = hi_r;
    assign irq_lo_o = lo_r;

endmodule // prio_sel

// file: tb/prio_sel_properties.sv
`timescale 1ns/1ps
module prio_chk import prio_sel_pkg::*;(input clk_i,reset_i,irq_hi_o,irq_lo_o,input [7:0] pend_i,
input apb_req_t apb_i,input apb_rsp_t apb_o);
logic [7:0] pr,en;
wire wr=apb_i.psel&apb_i.penable&apb_i.pwrite&apb_o.pready;
sequence setup_s; apb_i.psel&&!apb_i.penable; endsequence
default clocking @(posedge clk_i);endclocking default disable iff(reset_i);
always_ff @(posedge clk_i)
if(reset_i) {pr,en}<='0;
else if(wr&&apb_i.paddr==PRIO_SEL_OFFSET) pr<=apb_i.pwdata[7:0]&8'h7b;
else if(wr&&apb_i.paddr==ENABLE_OFFSET) en<=apb_i.pwdata[7:0]&8'h7b;
property rt(int b); pend_i==8'(1<<b)&&en[b]|=>irq_hi_o==$past(pr[b]); endproperty
conv_hi_a: assert property(rt(6))else $error("rt");
rx_hi_a: assert property(rt(5))else $error("rt");
tx_hi_a: assert property(rt(4))else $error("rt");
sync_hi_a: assert property(rt(3))else $error("rt");
tmb_hi_a: assert property(rt(1))else $error("rt");
tma_hi_a: assert property(rt(0))else $error("rt");
low_route_a: assert property(|(pend_i&en&~pr)|=>irq_lo_o)else $error("rt");
rsv_bits_a: assert property(apb_o.pready&&apb_i.paddr==PRIO_SEL_OFFSET|->(apb_o.prdata&8'h84)==0)else $error("rt");
ready_after_setup_a: assert property(setup_s|=>apb_o.pready)else $error("no ready");
ready_pulse_a: assert property(apb_o.pready|=>!apb_o.pready)else $error("ready held");
endmodule // prio_chk
bind prio_sel prio_chk c(.*);

// file: tb/test_prio_sel.sv
`timescale 1ns/1ps
module test_prio_sel;
import prio_sel_pkg::*;
logic clk_i=0,reset_i=1,irq_hi_o,irq_lo_o;
logic [7:0] pend_i=0,p,e;
apb_req_t apb_i='0;
apb_rsp_t apb_o;
int bad_count=0,compares=0,sd=98929,n;
prio_sel uut(.*);
initial forever #12.5 clk_i=~clk_i;
task chk(logic [31:0] s,x);
compares++;
if(s!==x) begin bad_count++; $display("unexpected %0t %h %h",$time,s,x); end
endtask
task final_report;
$display("%0d compares %0d bad",compares,bad_count);
if(bad_count==0&&compares>0) $display("Testbench passed");
else $display("Testbench failed");
$finish;
endtask
task bus(logic w,logic [11:0] a,logic [7:0] d);
apb_i<='{1'b1,1'b0,w,a,32'(d)};
@(posedge clk_i) apb_i.penable<=1;
n=0;
do @(posedge clk_i); while(!apb_o.pready&&++n<9);
if(n>8) begin bad_count++; final_report; end
if(!w) chk(apb_o.prdata,32'(d));
chk(apb_o.pslverr,a!=PRIO_SEL_OFFSET&&a!=PEND_STATUS_OFFSET&&a!=ENABLE_OFFSET);
apb_i<='0;
@(posedge clk_i);
endtask
initial begin
repeat(3) @(posedge clk_i);
reset_i<=0;
bus(0,PRIO_SEL_OFFSET,PRIO_SEL_RESET);
for(int i=0;i<40;i++) begin
p=8'($random(sd));
e=i<8?8'h7b:8'h7b&8'($random(sd));
bus(1,PRIO_SEL_OFFSET,p);
bus(1,ENABLE_OFFSET,e);
bus(0,PRIO_SEL_OFFSET,p&8'h7b);
bus(0,12'h00c,0);
pend_i<=i<8?8'(1<<i):8'($random(sd));
repeat(2) @(posedge clk_i);
chk({irq_hi_o,irq_lo_o},{|(pend_i&e&p),|(pend_i&e&~p)});
$display("test %0d",i);
end
final_report;
end
endmodule // test_prio_sel
